// *** rtl/rif_irq_status.sv ***
// interrupt flags, masks, fifo/collision status and tx length registers
//
// Behaviour
// - eight sources, oscillator bit 7 to collision bit 0
// - mask bit one blocks its source
// - mask and length registers zeroed by defaults
// - flags zeroed at power-up and set default
// - reading the flag register clears it
// - oscillator flag when enabled oscillator stabilises
// - field flag: peer target, oscillator off, field
// - field flag when collision avoidance aborts transmit
// - receive: flag when fill reaches threshold
// - transmit: flag when fill drops to threshold
// - receive threshold 28, or 24 when selected
// - transmit threshold 4, or 8 when selected
// - coding flag on parity or framing errors
// - collision flag only in type A mode
// - fill count bits 7..2, overflow bit 1
// - active receive from message start to end
// - fifo status zeroed by defaults and clear
// - collision bytes 7..4, bit 3..1, bit0 zero
// - collision register zeroed by defaults and clear
// - ten-bit length split across two registers
// - split byte valid bits, zero means complete
// - nibble and anticollision bits self-clear after transmit
`timescale 1ns/1ns

module rif_irq_status
  import rif_pkg::*;
(
  input wire logic core_clk, // 125 MHz system clock
  input wire logic rst_n, // synchronous reset, power-up
  input wire logic setDefault, // set default command pulse
  input wire logic clearCmd, // clear command pulse
  input wire rif_req_t req, // register access request
  output logic [7:0] regRdata, // read data, one cycle after rd
  input wire rif_evt_t evt, // engine events and status
  input wire logic rxThresholdSel, // receive water level select
  input wire logic txThresholdSel, // transmit water level select
  output rif_txctl_t txCtl, // transmit framing controls
  output logic irqLine // interrupt request, active high
);

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
    logic [5:0] unreadCount;
    logic overflow;
    logic rxAct;
    logic [3:0] collFullBytes;
    logic [2:0] collBitPos;
    logic [1:0] lenLow;
    logic [2:0] splitByteBits;
    logic nibbleReplyExpect;
    logic antiColl;
    logic [7:0] lenHigh;
    logic [7:0] rdata;
    logic oscOk;
    logic fieldSeen;
  } rif_state_t;

  rif_state_t s;
  rif_state_t next_s;
  logic [7:0] events;
  logic [7:0] readValue;
  logic [5:0] rxThreshold;
  logic [5:0] txThreshold;
  logic oscNow;
  logic fieldNow;
  logic defaults;
  logic flushStatus;
  logic readFlags;

  assign defaults = setDefault;
  assign flushStatus = setDefault | clearCmd;
  assign readFlags = req.rd && req.addr == OFS_IRQ_FLAGS;

  // thresholds picked by the configuration bits
  assign rxThreshold = rxThresholdSel ? RX_TH_SEL1 : RX_TH_SEL0;
  assign txThreshold = txThresholdSel ? TX_TH_SEL1 : TX_TH_SEL0;

  // level conditions turned into edges so a steady level flags once
  assign oscNow = evt.oscEnable & evt.oscStable;
  assign fieldNow = evt.peerTargetMode & ~evt.oscEnable & evt.extField;

  // event vector in flag bit order
  always_comb begin
    events = 8'h00;
    events[IRQ_OSC] = oscNow & ~s.oscOk;
    events[IRQ_FIELD] = (fieldNow & ~s.fieldSeen) | evt.caAbort;
    events[IRQ_FILL] = (evt.receiving && evt.fifoCount >= rxThreshold &&
      s.unreadCount < rxThreshold) ||
      (evt.transmitting && evt.fifoCount <= txThreshold &&
      s.unreadCount > txThreshold);
    events[IRQ_RX_END] = evt.rxEnd;
    events[IRQ_TX_END] = evt.txEnd;
    events[IRQ_CODING] = evt.parityErr | evt.framingErr;
    events[IRQ_CRC] = evt.crcErr;
    events[IRQ_COLL] = evt.collision & evt.isoAMode;
  end

  // read mux; unused bits and unmapped offsets read zero
  always_comb begin
    case (req.addr)
      OFS_IRQ_MASK: readValue = s.mask;
      OFS_IRQ_FLAGS: readValue = s.flags;
      OFS_FIFO_FILL_STATUS: readValue = {s.unreadCount, s.overflow,
        s.rxAct};
      OFS_COLLISION_POSITION: readValue = {s.collFullBytes, s.collBitPos,
        1'b0};
      OFS_TX_LENGTH_LOW: readValue = {s.lenLow, s.splitByteBits, 1'b0,
        s.nibbleReplyExpect, s.antiColl};
      OFS_TX_LENGTH_HIGH: readValue = s.lenHigh;
      default: readValue = READ_UNMAPPED;
    endcase
  end

  // next-state logic for the whole register set
  always_comb begin
    next_s = s;
    next_s.oscOk = oscNow;
    next_s.fieldSeen = fieldNow;
    next_s.rdata = req.rd ? readValue : s.rdata;
    // a new event in the read cycle survives the clear
    next_s.flags = (readFlags ? REG_RESET : s.flags) | events;
    // fifo status tracks the engine, overflow is held until flushed
    next_s.unreadCount = evt.fifoCount;
    next_s.overflow = s.overflow | evt.fifoOverflow;
    if (evt.rxStart) begin
      next_s.rxAct = 1'b1;
    end else if (evt.rxEnd) begin
      next_s.rxAct = 1'b0;
    end
    if (evt.collision && evt.isoAMode) begin
      next_s.collFullBytes = evt.collBytes;
      next_s.collBitPos = evt.collBit;
    end
    // hardware clears the one-shot frame bits when transmit ends
    if (evt.txEnd) begin
      next_s.nibbleReplyExpect = 1'b0;
      next_s.antiColl = 1'b0;
    end
    // host writes; a write in the end cycle re-arms for the next frame
    if (req.wr) begin
      case (req.addr)
        OFS_IRQ_MASK: next_s.mask = req.wdata;
        OFS_TX_LENGTH_LOW: begin
          next_s.lenLow = req.wdata[7:6];
          next_s.splitByteBits = req.wdata[5:3];
          next_s.nibbleReplyExpect = req.wdata[1];
          next_s.antiColl = req.wdata[0];
        end
        OFS_TX_LENGTH_HIGH: next_s.lenHigh = req.wdata;
        default: next_s.mask = next_s.mask;
      endcase
    end
    if (flushStatus) begin
      next_s.unreadCount = 6'h00;
      next_s.overflow = 1'b0;
      next_s.rxAct = 1'b0;
      next_s.collFullBytes = 4'h0;
      next_s.collBitPos = 3'h0;
    end
    if (defaults) begin
      next_s.flags = REG_RESET;
      next_s.mask = REG_RESET;
      {next_s.lenLow, next_s.splitByteBits, next_s.nibbleReplyExpect,
        next_s.antiColl} = 7'h00;
      next_s.lenHigh = REG_RESET;
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops, irq is the masked or
  assign regRdata = s.rdata;
  assign irqLine = |(s.flags & ~s.mask);
  assign txCtl.txByteCount = {s.lenHigh, s.lenLow};
  assign txCtl.splitByteBits = s.splitByteBits;
  assign txCtl.nibbleReplyExpect = s.nibbleReplyExpect;
  assign txCtl.antiCollFrame = s.antiColl;

  // checks; one clock domain, so reset masks every attempt at once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // interrupt line and masking
  irq_line_masked_a: assert property (
    irqLine == |(s.flags & ~s.mask))
    else $error("irq line does not match unmasked flags");

  mask_blocks_irq_a: assert property (
    (s.mask == 8'hFF) |-> !irqLine)
    else $error("fully masked flags still raise irq");

  mask_write_a: assert property (
    (req.wr && req.addr == OFS_IRQ_MASK && !defaults)
      |=> s.mask == $past(req.wdata))
    else $error("mask write did not land");

  // read clear and flag persistence
  read_clears_a: assert property (
    (readFlags && !defaults) |=> (s.flags == $past(events)))
    else $error("flag read did not clear flags");

  flags_hold_a: assert property (
    (!readFlags && !defaults)
      |=> ((s.flags & $past(s.flags)) == $past(s.flags)))
    else $error("flag dropped without a read");

  default_clears_a: assert property (
    setDefault |=> (s.flags == 8'h00 && s.mask == 8'h00 &&
      txCtl == '0))
    else $error("set default left state behind");

  // each source lands in its own bit
  osc_flag_a: assert property (
    (oscNow && !s.oscOk && !defaults) |=> s.flags[IRQ_OSC])
    else $error("oscillator stable not flagged");

  field_flag_a: assert property (
    (fieldNow && !s.fieldSeen && !defaults) |=> s.flags[IRQ_FIELD])
    else $error("external field not flagged");

  field_osc_on_a: assert property (
    (evt.oscEnable && !evt.caAbort && !s.flags[IRQ_FIELD])
      |=> !s.flags[IRQ_FIELD])
    else $error("field flagged with oscillator enabled");

  abort_flag_a: assert property (
    (evt.caAbort && !defaults) |=> s.flags[IRQ_FIELD])
    else $error("collision avoidance abort not flagged");

  rx_end_flag_a: assert property (
    (evt.rxEnd && !defaults) |=> s.flags[IRQ_RX_END])
    else $error("end of receive not flagged");

  tx_end_flag_a: assert property (
    (evt.txEnd && !defaults) |=> s.flags[IRQ_TX_END])
    else $error("end of transmit not flagged");

  coding_err_a: assert property (
    ((evt.parityErr || evt.framingErr) && !defaults)
      |=> s.flags[IRQ_CODING])
    else $error("coding error not flagged");

  crc_flag_a: assert property (
    (evt.crcErr && !defaults) |=> s.flags[IRQ_CRC])
    else $error("crc error not flagged");

  coll_flag_a: assert property (
    (evt.collision && evt.isoAMode && !defaults) |=> s.flags[IRQ_COLL])
    else $error("type A collision not flagged");

  coll_mode_a: assert property (
    (evt.collision && !evt.isoAMode && !s.flags[IRQ_COLL])
      |=> !s.flags[IRQ_COLL])
    else $error("collision flagged outside type A");

  // water level crossings for both selections
  rx_fill_flag_a: assert property (
    (evt.receiving && !rxThresholdSel && evt.fifoCount == 6'h1C &&
      s.unreadCount == 6'h1B && !defaults) |=> s.flags[IRQ_FILL])
    else $error("receive water level missed at 28");

  rx_thresh_a: assert property (
    (evt.receiving && rxThresholdSel && evt.fifoCount == RX_TH_SEL1 &&
      s.unreadCount < RX_TH_SEL1 && !defaults) |=> s.flags[IRQ_FILL])
    else $error("receive water level missed at 24");

  tx_fill_flag_a: assert property (
    (evt.transmitting && txThresholdSel && evt.fifoCount == 6'h08 &&
      s.unreadCount == 6'h09 && !defaults) |=> s.flags[IRQ_FILL])
    else $error("transmit water level missed at 8");

  tx_thresh_a: assert property (
    (evt.transmitting && !txThresholdSel && evt.fifoCount == TX_TH_SEL0 &&
      s.unreadCount > TX_TH_SEL0 && !defaults) |=> s.flags[IRQ_FILL])
    else $error("transmit water level missed at 4");

  // fifo status follows the engine and holds overflow
  count_mirror_a: assert property (
    !flushStatus |=> s.unreadCount == $past(evt.fifoCount))
    else $error("fill count does not follow fifo");

  fifo_range_a: assert property (
    s.unreadCount <= FIFO_FULL_COUNT)
    else $error("fill count above fifo capacity");

  overflow_set_a: assert property (
    (evt.fifoOverflow && !flushStatus) |=> s.overflow)
    else $error("fifo overflow not recorded");

  overflow_sticky_a: assert property (
    (s.overflow && !flushStatus) |=> s.overflow)
    else $error("overflow dropped without a clear");

  fill_read_a: assert property (
    (req.rd && req.addr == OFS_FIFO_FILL_STATUS)
      |=> regRdata[7:2] == $past(s.unreadCount))
    else $error("fill count read in wrong bits");

  rx_active_a: assert property (
    (evt.rxStart && !flushStatus) |=> s.rxAct)
    else $error("active receive not set at start");

  rx_active_end_a: assert property (
    (evt.rxEnd && !evt.rxStart) |=> !s.rxAct)
    else $error("active receive held after end");

  clear_status_a: assert property (
    clearCmd |=> (s.collFullBytes == 4'h0 && s.unreadCount == 6'h00 &&
      !s.overflow && !s.rxAct))
    else $error("clear left fifo or collision status");

  default_status_a: assert property (
    setDefault |=> (s.unreadCount == 6'h00 && s.collFullBytes == 4'h0 &&
      s.collBitPos == 3'h0))
    else $error("set default left fifo or collision status");

  // collision position latch
  coll_latch_a: assert property (
    (evt.collision && evt.isoAMode && !flushStatus)
      |=> (s.collFullBytes == $past(evt.collBytes) &&
      s.collBitPos == $past(evt.collBit)))
    else $error("collision position not latched");

  coll_hold_a: assert property (
    (!evt.collision && !flushStatus)
      |=> ($stable(s.collFullBytes) && $stable(s.collBitPos)))
    else $error("collision position changed without event");

  coll_zero_bit_a: assert property (
    (req.rd && req.addr == OFS_COLLISION_POSITION) |=> !regRdata[0])
    else $error("collision register bit 0 not zero");

  // transmit framing controls
  len_high_write_a: assert property (
    (req.wr && req.addr == OFS_TX_LENGTH_HIGH && !defaults)
      |=> txCtl.txByteCount[9:2] == $past(req.wdata))
    else $error("length high bits not loaded");

  len_low_write_a: assert property (
    (req.wr && req.addr == OFS_TX_LENGTH_LOW && !defaults)
      |=> (txCtl.txByteCount[1:0] == $past(req.wdata[7:6]) &&
      txCtl.splitByteBits == $past(req.wdata[5:3])))
    else $error("length low bits or split bits not loaded");

  frame_bits_clr_a: assert property (
    (evt.txEnd && !req.wr) |=> !txCtl.nibbleReplyExpect &&
      !txCtl.antiCollFrame)
    else $error("frame bits not cleared after transmit");

  irq_seen_c: cover property (irqLine ##1 readFlags ##1 !irqLine);
  fill_seen_c: cover property (events[IRQ_FILL]);
  low_fill_c: cover property (rxThresholdSel && events[IRQ_FILL]);
  coll_seen_c: cover property (evt.collision && evt.isoAMode);
  abort_seen_c: cover property (evt.caAbort ##1 s.flags[IRQ_FIELD]);

endmodule : rif_irq_status

// *** rtl/rif_pkg.sv ***
// package with register map, field layout and types for the irq/status block
package rif_pkg;

  // register offsets; the mask register offset is a local choice
  localparam logic [7:0] OFS_IRQ_MASK = 8'h07;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h08;
  localparam logic [7:0] OFS_FIFO_FILL_STATUS = 8'h09;
  localparam logic [7:0] OFS_COLLISION_POSITION = 8'h0A;
  localparam logic [7:0] OFS_TX_LENGTH_LOW = 8'h0B;
  localparam logic [7:0] OFS_TX_LENGTH_HIGH = 8'h0C;

  // reset value shared by every register
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // interrupt source positions, same in flags and mask
  localparam int IRQ_OSC = 7;
  localparam int IRQ_FIELD = 6;
  localparam int IRQ_FILL = 5;
  localparam int IRQ_RX_END = 4;
  localparam int IRQ_TX_END = 3;
  localparam int IRQ_CODING = 2;
  localparam int IRQ_CRC = 1;
  localparam int IRQ_COLL = 0;

  // fill thresholds in bytes and fifo capacity
  localparam logic [5:0] RX_TH_SEL0 = 6'h1C;
  localparam logic [5:0] RX_TH_SEL1 = 6'h18;
  localparam logic [5:0] TX_TH_SEL0 = 6'h04;
  localparam logic [5:0] TX_TH_SEL1 = 6'h08;
  localparam logic [5:0] FIFO_FULL_COUNT = 6'h20;

  // register access request from the serial front end
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rif_req_t;

  // status and event inputs from the framing engine and analog side
  typedef struct packed {
    logic oscEnable;
    logic oscStable;
    logic peerTargetMode;
    logic extField;
    logic caAbort;
    logic rxStart;
    logic rxEnd;
    logic txEnd;
    logic parityErr;
    logic framingErr;
    logic crcErr;
    logic collision;
    logic isoAMode;
    logic [3:0] collBytes;
    logic [2:0] collBit;
    logic [5:0] fifoCount;
    logic fifoOverflow;
    logic receiving;
    logic transmitting;
  } rif_evt_t;

  // transmit framing controls handed to the framing engine
  typedef struct packed {
    logic [9:0] txByteCount;
    logic [2:0] splitByteBits;
    logic nibbleReplyExpect;
    logic antiCollFrame;
  } rif_txctl_t;

endpackage : rif_pkg

// *** verif/rif_host_model.sv ***
// host controller model: register reads and writes over the access port
`timescale 1ns/1ns

module rif_host_model
  import rif_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic [7:0] regRdata, // read data from the block
  output rif_req_t req // register access request
);
  // idle port from time zero
  initial begin
    req = '0;
  end

  // one write strobe, held across exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge core_clk);
    // released data is inverted so stale values never look valid
    req <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : wr

  // read strobe; data lands on the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~req.wdata};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
endmodule : rif_host_model

// *** verif/rif_irq_status_tb.sv ***
// self-checking bench for the irq flag, mask and frame status block
`timescale 1ns/1ns

`define CHK(g, w) begin comparisons++; if ((g) !== (w)) begin \
  nMismatch++; $display("CHECK FAILED %0t got %h want %h", $time, g, w); \
  end end

module rif_irq_status_tb;
  import rif_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic setDefault = 1'b0;
  logic clearCmd = 1'b0;
  logic rxThresholdSel = 1'b0;
  logic txThresholdSel = 1'b1;
  rif_req_t req;
  rif_evt_t evt = '0;
  rif_evt_t idle = '0;
  rif_txctl_t txCtl;
  logic [7:0] regRdata;
  logic irqLine;
  int nMismatch = 0;
  int comparisons = 0;

  // 125 MHz
  always #4 core_clk = ~core_clk;

  rif_irq_status DUT (.core_clk(core_clk), .rst_n(rst_n),
    .setDefault(setDefault), .clearCmd(clearCmd), .req(req),
    .regRdata(regRdata), .evt(evt), .rxThresholdSel(rxThresholdSel),
    .txThresholdSel(txThresholdSel), .txCtl(txCtl), .irqLine(irqLine));

  rif_host_model host (.core_clk(core_clk), .regRdata(regRdata),
    .req(req));

  task automatic stop_test();
    if (nMismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // read a register and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(d, e)
  endtask : rc

  // one-cycle event, then flags read back and cleared by the read
  task automatic ev(input rif_evt_t e, input logic [7:0] x);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= idle;
    #1 `CHK(irqLine, |x)
    rc(OFS_IRQ_FLAGS, x);
    rc(OFS_IRQ_FLAGS, 8'h00);
    `CHK(irqLine, 1'b0)
  endtask : ev

  // every register at default, unmapped offset reads zero
  task automatic zero_regs();
    for (int a = 7; a <= 12; a++) begin
      rc(8'(a), REG_RESET);
    end
    rc(8'h1F, READ_UNMAPPED);
    `CHK(txCtl, 15'h0000)
  endtask : zero_regs

  // watchdog well beyond the test length
  initial begin
    repeat (20000) @(posedge core_clk);
    nMismatch++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    zero_regs();
    // each source at its own position
    ev('{oscEnable: 1, oscStable: 1, default: 0}, 8'h80);
    ev('{peerTargetMode: 1, extField: 1, default: 0}, 8'h40);
    ev('{caAbort: 1, default: 0}, 8'h40);
    ev('{peerTargetMode: 1, extField: 1, oscEnable: 1, default: 0},
      8'h00);
    ev('{rxEnd: 1, default: 0}, 8'h10);
    ev('{parityErr: 1, default: 0}, 8'h04);
    ev('{framingErr: 1, default: 0}, 8'h04);
    ev('{crcErr: 1, default: 0}, 8'h02);
    ev('{collision: 1, collBytes: 4'h5, default: 0}, 8'h00);
    ev('{collision: 1, isoAMode: 1, collBytes: 4'h5, collBit: 3'h3,
      default: 0}, 8'h01);
    rc(OFS_COLLISION_POSITION, 8'h56);
    // water level on crossing, receive then transmit
    idle = '{receiving: 1, fifoCount: 6'h1B, default: 0};
    ev('{receiving: 1, fifoCount: 6'h1C, default: 0}, 8'h20);
    rc(OFS_FIFO_FILL_STATUS, 8'h6C);
    idle = '{transmitting: 1, fifoCount: 6'h09, default: 0};
    ev(idle, 8'h00);
    ev('{transmitting: 1, fifoCount: 6'h08, default: 0}, 8'h20);
    // other selections: 24 on receive, 4 on transmit
    @(posedge core_clk);
    rxThresholdSel <= 1'b1;
    txThresholdSel <= 1'b0;
    idle = '{receiving: 1, fifoCount: 6'h17, default: 0};
    ev(idle, 8'h00);
    ev('{receiving: 1, fifoCount: 6'h18, default: 0}, 8'h20);
    idle = '{transmitting: 1, fifoCount: 6'h05, default: 0};
    ev(idle, 8'h00);
    ev('{transmitting: 1, fifoCount: 6'h04, default: 0}, 8'h20);
    idle = '0;
    ev('{fifoOverflow: 1, rxStart: 1, default: 0}, 8'h00);
    rc(OFS_FIFO_FILL_STATUS, 8'h03);
    ev('{rxEnd: 1, default: 0}, 8'h10);
    rc(OFS_FIFO_FILL_STATUS, 8'h02);
    @(posedge core_clk);
    clearCmd <= 1'b1;
    @(posedge core_clk);
    clearCmd <= 1'b0;
    rc(OFS_FIFO_FILL_STATUS, 8'h00);
    rc(OFS_COLLISION_POSITION, 8'h00);
    // masked source latches but keeps the line low
    host.wr(OFS_IRQ_MASK, 8'hFF);
    rc(OFS_IRQ_MASK, 8'hFF);
    @(posedge core_clk);
    evt <= '{crcErr: 1, default: 0};
    @(posedge core_clk);
    evt <= idle;
    #1 `CHK(irqLine, 1'b0)
    host.wr(OFS_IRQ_MASK, 8'hFD);
    #1 `CHK(irqLine, 1'b1)
    rc(OFS_IRQ_FLAGS, 8'h02);
    host.wr(OFS_IRQ_MASK, 8'h00);
    // full length, all framing bits set before the transmission
    host.wr(OFS_TX_LENGTH_LOW, 8'hFF);
    host.wr(OFS_TX_LENGTH_HIGH, 8'hFF);
    #1 `CHK(txCtl, {10'h3FF, 3'h7, 1'b1, 1'b1})
    rc(OFS_TX_LENGTH_LOW, 8'hFB);
    ev('{txEnd: 1, default: 0}, 8'h08);
    rc(OFS_TX_LENGTH_LOW, 8'hF8);
    host.wr(OFS_IRQ_MASK, 8'h5A);
    ev('{oscEnable: 1, oscStable: 1, default: 0}, 8'h80);
    @(posedge core_clk);
    evt <= '{rxEnd: 1, default: 0};
    setDefault <= 1'b1;
    @(posedge core_clk);
    evt <= idle;
    setDefault <= 1'b0;
    zero_regs();
    // reset in mid-run drops a pending flag and the length
    host.wr(OFS_TX_LENGTH_HIGH, 8'h3C);
    @(posedge core_clk);
    evt <= '{crcErr: 1, default: 0};
    @(posedge core_clk);
    evt <= idle;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 `CHK(irqLine, 1'b0)
    zero_regs();
    stop_test();
  end
endmodule : rif_irq_status_tb
